/* hw/psvr_map.vh */
/*
 * Constants of the panel settings and video route block: register
 * offsets, field positions, reset values, codes and timing counts.
 * Assumes it is included once by bare name into the design file.
 */
`ifndef PSVR_MAP_VH
`define PSVR_MAP_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port).
// ----------------------------------------------------------------
`define PSVR_REG_CTRL    4'h0
`define PSVR_REG_STATUS  4'h1
`define PSVR_REG_TRIM    4'h2
`define PSVR_REG_FRAME   4'h3

// ----------------------------------------------------------------
// Control fields and reset values.
// ----------------------------------------------------------------
`define PSVR_CLK_LSB     0
`define PSVR_POS_LSB     4
`define PSVR_CLK_RST     3'h0
`define PSVR_POS_RST     2'h0

// Clock reference codes; no code exists for vertical-interval code.
`define PSVR_CLK_INT     3'h0
`define PSVR_CLK_VIDIN   3'h1
`define PSVR_CLK_VIDREF  3'h2
`define PSVR_CLK_LTC     3'h3
`define PSVR_CLK_WORD    3'h4
`define PSVR_CLK_AES     3'h5
`define PSVR_CLK_BIPH    3'h6
`define PSVR_CLK_LAST    3'h6

// Positional reference codes.
`define PSVR_POS_GEN     2'h0
`define PSVR_POS_LTC     2'h1
`define PSVR_POS_VITC    2'h2
`define PSVR_POS_BIPH    2'h3

// ----------------------------------------------------------------
// Display modes.
// ----------------------------------------------------------------
`define PSVR_DISP_TC     2'h0
`define PSVR_DISP_TLBL   2'h1
`define PSVR_DISP_TVAL   2'h2
`define PSVR_DISP_FLBL   2'h3

// ----------------------------------------------------------------
// Trim range and step (one step is 1/64 sample period).
// ----------------------------------------------------------------
`define PSVR_TRIM_MAX    11'h3E7
`define PSVR_TRIM_MIN    11'h419
`define PSVR_TRIM_STEP   11'h001

// ----------------------------------------------------------------
// Nonvolatile store words and default parameter values.
// ----------------------------------------------------------------
`define PSVR_NV_TRIM     3'h0
`define PSVR_NV_LAST     3'h7
`define PSVR_DEF_START_H 16'h0000
`define PSVR_DEF_START_L 16'h0000
`define PSVR_DEF_GAIN    16'hFFFF
`define PSVR_DEF_RATE    16'h0000
`define PSVR_DEF_FWHEEL  16'h0008
`define PSVR_DEF_PPF     16'h0064
`define PSVR_DEF_VLINES  16'h0E10

// ----------------------------------------------------------------
// Timing: cycles after reset release before straps are judged.
// ----------------------------------------------------------------
`define PSVR_STRAP_WAIT  3'h4

`endif

/* hw/psvr_top.v */
/*
 * Panel settings manager and video route selector of a studio
 * synchronizer: front-panel oscillator trim edit and commit, the
 * power-up factory restore, and routing of the timecode path.
 * Assumes debounced-free switch and video frame pulses arriving
 * from outside the clock domain, and an external nonvolatile store
 * that returns the committed trim and accepts word writes.
 */
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "psvr_map.vh"

module psvr_top (
    input  wire        i_clk_sys,
    input  wire        i_arst_n,
    input  wire        i_sw_set,
    input  wire        i_sw_up,
    input  wire        i_sw_down,
    input  wire        i_vid_in_frame,
    input  wire        i_vid_ref_frame,
    input  wire [10:0] i_nv_trim,
    input  wire [3:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_disp_mode,
    output reg  [10:0] o_disp_trim,
    output reg  [10:0] o_osc_trim,
    output reg  [2:0]  o_resolver_sel,
    output reg         o_tc_use_ref,
    output reg         o_frame_edge,
    output reg  [23:0] o_frame_addr,
    output reg         o_nv_wr,
    output reg  [2:0]  o_nv_addr,
    output reg  [15:0] o_nv_data
);

    // ------------------------------------------------------------
    // Panel state codes.
    // ------------------------------------------------------------
    localparam [2:0] ST_STRAP = 3'h0;
    localparam [2:0] ST_TC    = 3'h1;
    localparam [2:0] ST_LABEL = 3'h2;
    localparam [2:0] ST_VALUE = 3'h3;
    localparam [2:0] ST_FACT  = 3'h4;

    reg  [4:0]  sync1;
    reg  [4:0]  sync2;
    reg  [4:0]  sync3;
    reg  [4:0]  clean;
    reg  [4:0]  clean_d;
    wire [4:0]  raw_in;
    wire [4:0]  rise;
    reg  [2:0]  state;
    reg  [2:0]  wait_cnt;
    reg  [10:0] edit_trim;
    reg  [2:0]  clk_ref;
    reg  [1:0]  pos_ref;
    reg  [2:0]  fact_ptr;
    reg         fact_busy;
    reg         trim_loaded;
    reg         sel_frame_d;
    wire        sel_frame;
    wire        next_tc_ref;
    wire        async_warn;

    assign raw_in = {i_vid_ref_frame, i_vid_in_frame,
                     i_sw_down, i_sw_up, i_sw_set};
    assign rise   = clean & ~clean_d;

    // ------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------

    // Three stages per pin; a change is taken only once stages two
    // and three agree, which also rejects one-cycle glitches.
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            always @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    sync1[g]   <= 1'b0;
                    sync2[g]   <= 1'b0;
                    sync3[g]   <= 1'b0;
                    clean[g]   <= 1'b0;
                    clean_d[g] <= 1'b0;
                end else begin
                    sync1[g]   <= raw_in[g];
                    sync2[g]   <= sync1[g];
                    sync3[g]   <= sync2[g];
                    clean_d[g] <= clean[g];
                    if (sync2[g] == sync3[g]) begin
                        clean[g] <= sync3[g];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Front-panel state machine and trim edit.
    // ------------------------------------------------------------

    // The strap wait lets held switches pass the synchronisers before
    // they are judged; the restore label then shows while still held.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state       <= ST_STRAP;
            wait_cnt    <= 3'h0;
            edit_trim   <= 11'h000;
            o_osc_trim  <= 11'h000;
            trim_loaded <= 1'b0;
            fact_busy   <= 1'b0;
        end else begin
            fact_busy <= 1'b0;
            case (state)
                ST_STRAP: begin
                    if (!trim_loaded) begin
                        o_osc_trim  <= i_nv_trim;
                        trim_loaded <= 1'b1;
                    end
                    if (wait_cnt == `PSVR_STRAP_WAIT) begin
                        if (clean[1] && clean[2]) begin
                            state     <= ST_FACT;
                            fact_busy <= 1'b1;
                        end else begin
                            state <= ST_TC;
                        end
                    end else begin
                        wait_cnt <= wait_cnt + 3'h1;
                    end
                end
                ST_FACT: begin
                    fact_busy <= (fact_ptr != `PSVR_NV_LAST);
                    if (!clean[1] && !clean[2]) begin
                        if (fact_ptr == `PSVR_NV_LAST) begin
                            state <= ST_TC;
                        end
                    end
                end
                ST_TC: begin
                    if (rise[0]) begin
                        state <= ST_LABEL;
                    end
                end
                ST_LABEL: begin
                    if (rise[0]) begin
                        state     <= ST_VALUE;
                        edit_trim <= o_osc_trim;
                    end else if (rise[2]) begin
                        state <= ST_TC;
                    end
                end
                ST_VALUE: begin
                    if (rise[0]) begin
                        o_osc_trim <= edit_trim;
                        state      <= ST_TC;
                    end else if (rise[1]) begin
                        if (edit_trim != `PSVR_TRIM_MAX) begin
                            edit_trim <= edit_trim + `PSVR_TRIM_STEP;
                        end
                    end else if (rise[2]) begin
                        if (edit_trim != `PSVR_TRIM_MIN) begin
                            edit_trim <= edit_trim - `PSVR_TRIM_STEP;
                        end
                    end
                end
                default: begin
                    state <= ST_TC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Display outputs.
    // ------------------------------------------------------------

    // The shown value is the edit copy; an edit ends only by a Set commit.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_disp_mode <= `PSVR_DISP_TC;
            o_disp_trim <= 11'h000;
        end else begin
            o_disp_trim <= edit_trim;
            case (state)
                ST_LABEL: o_disp_mode <= `PSVR_DISP_TLBL;
                ST_VALUE: o_disp_mode <= `PSVR_DISP_TVAL;
                ST_FACT:  o_disp_mode <= `PSVR_DISP_FLBL;
                default:  o_disp_mode <= `PSVR_DISP_TC;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Nonvolatile store writes.
    // ------------------------------------------------------------

    // Default word for each user parameter slot of the store.
    function [15:0] psvr_default;
        input [2:0] slot;
        begin
            case (slot)
                3'h1:    psvr_default = `PSVR_DEF_START_H;
                3'h2:    psvr_default = `PSVR_DEF_START_L;
                3'h3:    psvr_default = `PSVR_DEF_GAIN;
                3'h4:    psvr_default = `PSVR_DEF_RATE;
                3'h5:    psvr_default = `PSVR_DEF_FWHEEL;
                3'h6:    psvr_default = `PSVR_DEF_PPF;
                3'h7:    psvr_default = `PSVR_DEF_VLINES;
                default: psvr_default = 16'h0000;
            endcase
        end
    endfunction

    // Restore walks slots one to seven and never visits slot zero,
    // which holds the trim; a commit writes slot zero alone.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fact_ptr  <= 3'h0;
            o_nv_wr   <= 1'b0;
            o_nv_addr <= 3'h0;
            o_nv_data <= 16'h0000;
        end else begin
            o_nv_wr <= 1'b0;
            if (fact_busy && fact_ptr != `PSVR_NV_LAST) begin
                fact_ptr  <= fact_ptr + 3'h1;
                o_nv_wr   <= 1'b1;
                o_nv_addr <= fact_ptr + 3'h1;
                o_nv_data <= psvr_default(fact_ptr + 3'h1);
            end else if (state == ST_VALUE && rise[0]) begin
                o_nv_wr   <= 1'b1;
                o_nv_addr <= `PSVR_NV_TRIM;
                o_nv_data <= {{5{edit_trim[10]}}, edit_trim};
            end
        end
    end

    // ------------------------------------------------------------
    // Video route and frame alignment.
    // ------------------------------------------------------------

    // Reference input only for video clock with generated position.
    assign next_tc_ref = ((clk_ref == `PSVR_CLK_VIDIN) ||
                          (clk_ref == `PSVR_CLK_VIDREF)) &&
                         (pos_ref == `PSVR_POS_GEN);
    assign sel_frame   = o_tc_use_ref ? clean[4] : clean[3];
    // Internal crystal with generated position drifts against video.
    assign async_warn  = (clk_ref == `PSVR_CLK_INT) &&
                         (pos_ref == `PSVR_POS_GEN);

    // One address step per detected frame edge keeps the count free of
    // repeats and skips, provided the edges come from synchronous video.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tc_use_ref   <= 1'b0;
            o_resolver_sel <= `PSVR_CLK_RST;
            sel_frame_d    <= 1'b0;
            o_frame_edge   <= 1'b0;
            o_frame_addr   <= 24'h000000;
        end else begin
            o_tc_use_ref   <= next_tc_ref;
            o_resolver_sel <= clk_ref;
            sel_frame_d    <= sel_frame;
            o_frame_edge   <= sel_frame & ~sel_frame_d;
            if (sel_frame & ~sel_frame_d) begin
                o_frame_addr <= o_frame_addr + 24'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port.
    // ------------------------------------------------------------

    // Out-of-range clock codes are dropped so no vertical-interval
    // clock choice can ever be stored.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clk_ref <= `PSVR_CLK_RST;
            pos_ref <= `PSVR_POS_RST;
        end else if (i_wr && i_addr == `PSVR_REG_CTRL) begin
            pos_ref <= i_wdata[`PSVR_POS_LSB+1:`PSVR_POS_LSB];
            if (i_wdata[`PSVR_CLK_LSB+2:`PSVR_CLK_LSB] <=
                `PSVR_CLK_LAST) begin
                clk_ref <= i_wdata[`PSVR_CLK_LSB+2:`PSVR_CLK_LSB];
            end
        end
    end

    // Read data stand in the cycle after the strobe only.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `PSVR_REG_CTRL:
                    o_rdata <= {26'h0000000, pos_ref, 1'b0, clk_ref};
                `PSVR_REG_STATUS:
                    o_rdata <= {24'h000000, async_warn, o_tc_use_ref,
                                o_disp_mode, 1'b0, state};
                `PSVR_REG_TRIM:
                    o_rdata <= {{21{o_osc_trim[10]}}, o_osc_trim};
                `PSVR_REG_FRAME:
                    o_rdata <= {8'h00, o_frame_addr};
                default:
                    o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule

/* bench/psvr_asserts.sv */
/*
 * Checker for the panel settings and video route block.
 * Assumes it is bound onto psvr_top, one clock, async low reset.
 */
`timescale 1ns/1ns
module psvr_asserts (
    input wire        i_clk_sys,
    input wire        i_arst_n,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire [1:0]  o_disp_mode,
    input wire [10:0] o_disp_trim,
    input wire [10:0] o_osc_trim,
    input wire [2:0]  o_resolver_sel,
    input wire        o_tc_use_ref,
    input wire        o_frame_edge,
    input wire [23:0] o_frame_addr,
    input wire        o_nv_wr,
    input wire [2:0]  o_nv_addr,
    input wire [15:0] o_nv_data
);
    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    // Default contents of each slot from one to seven after a restore.
    function automatic logic [15:0] psvr_def(input logic [2:0] a);
        case (a)
            3'h3: psvr_def = 16'hFFFF;
            3'h5: psvr_def = 16'h0008;
            3'h6: psvr_def = 16'h0064;
            3'h7: psvr_def = 16'h0E10;
            default: psvr_def = 16'h0000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------
    property p_trim_show;
        o_disp_mode == 2'h2 |-> $signed(o_disp_trim) <= 11'sd999
            && $signed(o_disp_trim) >= -11'sd999;
    endproperty
    a_trim_show: assert property (p_trim_show)
        else $error("shown trim out of range");
    property p_trim_keep;
        $signed(o_osc_trim) <= 11'sd999 && $signed(o_osc_trim) >= -11'sd999;
    endproperty
    a_trim_keep: assert property (p_trim_keep)
        else $error("committed trim out of range");
    property p_open_seq;
        o_disp_mode == 2'h0 |=> o_disp_mode != 2'h2;
    endproperty
    a_open_seq: assert property (p_open_seq)
        else $error("trim value opened without label");
    // Commit writes slot zero with the sign extended trim, in the same
    // cycle in which the committed trim register takes the new value.
    property p_commit;
        o_nv_wr && o_nv_addr == 3'h0
            |-> o_nv_data[15:11] == {5{o_nv_data[10]}}
            && o_osc_trim == o_nv_data[10:0];
    endproperty
    a_commit: assert property (p_commit)
        else $error("commit data and trim disagree");
    property p_def;
        o_nv_wr && o_nv_addr != 3'h0 |-> o_nv_data == psvr_def(o_nv_addr);
    endproperty
    a_def: assert property (p_def)
        else $error("restored default wrong");
    property p_no_vitc;
        o_resolver_sel <= 3'h6;
    endproperty
    a_no_vitc: assert property (p_no_vitc)
        else $error("illegal clock reference");
    property p_route;
        o_tc_use_ref |-> o_resolver_sel == 3'h1 || o_resolver_sel == 3'h2;
    endproperty
    a_route: assert property (p_route)
        else $error("reference route without video clock");
    property p_edge_step;
        o_frame_edge |-> o_frame_addr == $past(o_frame_addr) + 24'h1;
    endproperty
    a_edge_step: assert property (p_edge_step)
        else $error("frame address did not advance by one");
    property p_edge_hold;
        !o_frame_edge |-> $stable(o_frame_addr);
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("frame address moved without edge");
    property p_rd_idle;
        !i_rd |=> o_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read");

    // Main scenarios reached.
    c_fac: cover property (o_disp_mode == 2'h3);
    c_commit: cover property (o_nv_wr && o_nv_addr == 3'h0);
    c_ref_edge: cover property (o_tc_use_ref && o_frame_edge);
endmodule

bind psvr_top psvr_asserts chk_u (.i_clk_sys, .i_arst_n, .i_rd, .o_rdata,
    .o_disp_mode, .o_disp_trim, .o_osc_trim, .o_resolver_sel,
    .o_tc_use_ref, .o_frame_edge, .o_frame_addr, .o_nv_wr, .o_nv_addr,
    .o_nv_data);

/* bench/psvr_operator.sv */
/*
 * Front panel operator: presses Set, Up and Down switches.
 * Assumes the caller runs its tasks from the clock's domain.
 */
`timescale 1ns/1ns
module psvr_operator (
    input  wire  i_clk,
    output logic o_sw_set,
    output logic o_sw_up,
    output logic o_sw_down
);
    // All switches released at power-on.
    initial {o_sw_set, o_sw_up, o_sw_down} = 3'b000;

    // Held levels for the power-up restore gesture.
    task automatic hold(input logic up, input logic down);
        @(posedge i_clk);
        o_sw_up   <= up;
        o_sw_down <= down;
    endtask

    // One press, long enough for the synchroniser, then a release gap.
    task automatic press(input logic s, input logic u, input logic d);
        @(posedge i_clk);
        {o_sw_set, o_sw_up, o_sw_down} <= {s, u, d};
        repeat (8) @(posedge i_clk);
        {o_sw_set, o_sw_up, o_sw_down} <= 3'b000;
        repeat (10) @(posedge i_clk);
        #1;
    endtask
endmodule

/* bench/psvr_top_tb.sv */
/*
 * Self-checking bench for psvr_top: register port, routing, frames,
 * trim menu and factory restore. Assumes the operator model drives
 * the switches and the bench plays the nonvolatile store.
 */
`timescale 1ns/1ns
module psvr_top_tb;
    logic        i_clk_sys, i_arst_n, i_vid_in_frame, i_vid_ref_frame;
    logic        i_wr, i_rd;
    logic [10:0] i_nv_trim;
    logic [3:0]  i_addr;
    logic [31:0] i_wdata, d;
    wire         sw_set, sw_up, sw_down, o_tc_use_ref, o_frame_edge;
    wire         o_nv_wr;
    wire  [31:0] o_rdata;
    wire  [1:0]  o_disp_mode;
    wire  [10:0] o_disp_trim, o_osc_trim;
    wire  [2:0]  o_resolver_sel, o_nv_addr;
    wire  [23:0] o_frame_addr;
    wire  [15:0] o_nv_data;
    int          miscompares, checks, nv_cnt, nv0_cnt, n, fe_cnt;
    logic [15:0] nv_seen [0:7];
    logic [15:0] nv_last;
    logic [15:0] defs [1:7] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000,
                                16'h0008, 16'h0064, 16'h0E10};

    psvr_top dut_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_sw_set(sw_set), .i_sw_up(sw_up), .i_sw_down(sw_down),
        .i_vid_in_frame(i_vid_in_frame), .i_vid_ref_frame(i_vid_ref_frame),
        .i_nv_trim(i_nv_trim), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_disp_mode(o_disp_mode), .o_disp_trim(o_disp_trim),
        .o_osc_trim(o_osc_trim), .o_resolver_sel(o_resolver_sel),
        .o_tc_use_ref(o_tc_use_ref), .o_frame_edge(o_frame_edge),
        .o_frame_addr(o_frame_addr), .o_nv_wr(o_nv_wr),
        .o_nv_addr(o_nv_addr), .o_nv_data(o_nv_data));
    psvr_operator op_u (.i_clk(i_clk_sys), .o_sw_set(sw_set),
        .o_sw_up(sw_up), .o_sw_down(sw_down));

    // ------------------------------------------------------------
    // Clock, store monitor and watchdog.
    // ------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // Record every store write and frame edge; slot zero on its own.
    always @(posedge i_clk_sys) begin
        if (o_frame_edge === 1'b1) fe_cnt++;
        if (o_nv_wr === 1'b1) begin
            nv_cnt++;
            if (o_nv_addr === 3'h0) nv0_cnt++;
            nv_seen[o_nv_addr] = o_nv_data;
            nv_last = o_nv_data;
        end
    end

    // A hang is far longer than the whole sequence of about 660 cycles.
    initial begin
        repeat (8000) @(posedge i_clk_sys);
        miscompares++;
        summarize();
    end

    // ------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // Power-up with a given stored trim, switches held or not.
    task automatic do_reset(input logic [10:0] nv, input logic fac);
        i_arst_n <= 1'b0; i_nv_trim <= nv;
        op_u.hold(fac, fac);
        repeat (5) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (30) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic frame(input logic use_ref);
        @(posedge i_clk_sys);
        if (use_ref) i_vid_ref_frame <= 1'b1;
        else i_vid_in_frame <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        i_vid_ref_frame <= 1'b0; i_vid_in_frame <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        #1;
    endtask
    // Open trim, step twice towards a limit, commit, then reopen label.
    task automatic trim_case(input logic [10:0] nv, input logic up,
                             input logic [10:0] lim, input logic [15:0] nvd);
        do_reset(nv, 1'b0);
        op_u.press(1, 0, 0); chk(o_disp_mode, 2'h1);
        op_u.press(1, 0, 0); chk(o_disp_mode, 2'h2);
        chk(o_disp_trim, nv);
        op_u.press(0, up, !up); chk(o_disp_trim, lim);
        op_u.press(0, up, !up); chk(o_disp_trim, lim);
        n = nv0_cnt;
        op_u.press(1, 0, 0); chk(o_disp_mode, 2'h0);
        chk(o_osc_trim, lim);
        chk(nv0_cnt - n, 1);
        chk(nv_last, nvd);
        op_u.press(1, 0, 0); chk(o_disp_mode, 2'h1);
        op_u.press(0, 0, 1); chk(o_disp_mode, 2'h0);
    endtask
    task automatic summarize();
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        i_arst_n = 1'b0; i_vid_in_frame = 1'b0; i_vid_ref_frame = 1'b0;
        i_wr = 1'b0; i_rd = 1'b0; i_addr = 4'h0; i_wdata = 32'h0;
        i_nv_trim = 11'h005; miscompares = 0; checks = 0;
        nv_cnt = 0; nv0_cnt = 0; fe_cnt = 0;
        do_reset(11'h005, 1'b0);
        chk(o_osc_trim, 11'h005);
        chk(nv_cnt, 0);
        for (int c = 0; c < 7; c++) begin
            for (int p = 0; p < 4; p++) begin
                wr(4'h0, 32'(p * 16 + c));
                @(posedge i_clk_sys);
                #1 chk(o_resolver_sel, c);
                chk(o_tc_use_ref, (c == 1 || c == 2) && p == 0);
                rd(4'h1, d);
                chk(d[7:6], {c == 0 && p == 0,
                             (c == 1 || c == 2) && p == 0});
            end
        end
        wr(4'h0, 32'h17);
        rd(4'h0, d); chk(d, 32'h16);
        chk(o_resolver_sel, 3'h6);
        wr(4'h9, 32'hFFFFFFFF);
        rd(4'h9, d); chk(d, 32'h0);
        rd(4'h2, d); chk(d, 32'h5);
        // Video clock with generated position selects the reference.
        wr(4'h0, 32'h01);
        frame(1'b1); chk(o_frame_addr, 24'h1);
        frame(1'b0); chk(o_frame_addr, 24'h1);
        wr(4'h0, 32'h10);
        frame(1'b1); chk(o_frame_addr, 24'h1);
        frame(1'b0); chk(o_frame_addr, 24'h2);
        rd(4'h3, d); chk(d, 32'h2);
        chk(fe_cnt, 2);
        trim_case(11'h3E6, 1'b1, 11'h3E7, 16'h03E7);
        trim_case(11'h41A, 1'b0, 11'h419, 16'hFC19);
        // Restore with Up and Down held through power-up.
        n = nv_cnt; nv0_cnt = 0;
        do_reset(11'h123, 1'b1);
        chk(o_disp_mode, 2'h3);
        op_u.hold(1'b0, 1'b0);
        repeat (20) @(posedge i_clk_sys);
        #1 chk(o_disp_mode, 2'h0);
        chk(nv_cnt - n, 7);
        chk(nv0_cnt, 0);
        chk(o_osc_trim, 11'h123);
        for (int k = 1; k < 8; k++) chk(nv_seen[k], defs[k]);
        summarize();
    end
endmodule
